// File: design/clkg_pkg.sv
// Purpose: Shared constants and types of the clock generator control logic.
// Assumes: Core clock of 100 MHz; configuration bytes sit one per APB word.
// Notes:   Holds offsets, reset values, bit positions and the strap timing.
package clkg_pkg;

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int unsigned CORE_CLK_MHZ = 100; // Core clock rate in MHz
   localparam int unsigned STRAP_TIME_US = 2000; // Strap window, 2 ms
   // Window length in core cycles
   localparam int unsigned STRAP_CYCLES_DEF = STRAP_TIME_US * CORE_CLK_MHZ;

   // ==========================================================================
   // Register map
   // ==========================================================================
   localparam int unsigned CFG_BYTES = 8; // Configuration bytes 0..7
   localparam logic [7:0] CFG_BASE_OFS = 8'h00; // Byte n at base plus 4n
   localparam logic [7:0] STATUS_OFS = 8'h20; // Read-only status word
   // Power-up values of configuration bytes 0..7
   localparam logic [7:0] CFG_RST [CFG_BYTES] = '{8'h04, 8'h0F, 8'h5F, 8'h37,
                                                  8'h00, 8'h13, 8'h00, 8'h00};

   // ==========================================================================
   // Field positions inside the configuration bytes
   // ==========================================================================
   localparam int unsigned B0_SEL0_BIT = 4; // SEL_2..SEL_0 at bits 6..4
   localparam int unsigned B0_HWSW_BIT = 3; // One selects software settings
   localparam int unsigned B0_SEL4_BIT = 2;
   localparam int unsigned B0_SEL3_BIT = 1; // Also the software spread enable
   localparam int unsigned B2_PCI1_BIT = 0; // PCI1..PCI5 at bits 0..4
   localparam int unsigned B2_PCI0_BIT = 6;
   localparam int unsigned B3_SEL48_BIT = 6; // Zero gives 24 MHz
   localparam int unsigned B3_USB_EN_BIT = 5;
   localparam int unsigned B3_SIO_EN_BIT = 4;
   localparam int unsigned B3_MEM_EN_BIT = 0; // Three groups of four, bits 0..2
   localparam int unsigned B5_REF_CLK_OUT0_BIT = 0;
   localparam int unsigned B5_REF_CLK_OUT1_BIT = 1;

   // ==========================================================================
   // Strap pins, in order of the strap vector
   // ==========================================================================
   localparam int unsigned STRAPS = 5;
   localparam int unsigned STRAP_FS0 = 0; // Ref output one
   localparam int unsigned STRAP_FS1 = 1; // Bus clock one
   localparam int unsigned STRAP_FS2 = 2; // USB reference output
   localparam int unsigned STRAP_FS3 = 3; // Super I/O output
   localparam int unsigned STRAP_MODE = 4; // Bus clock zero
   localparam logic MODE_CPU_STOP = 1'b0; // Shared pin is the stop input

   // Effective frequency selection
   typedef struct packed {
      logic sw; // Settings from software
      logic [4:0] code; // Selection code, strap codes in low four bits
      logic spread; // Spread modulation enabled
   } clkg_sel_t;

   // Read-only status word, 32 bits
   typedef struct packed {
      logic [16:0] rsvd;
      logic cpu_stopped;
      logic power_down_n;
      clkg_sel_t sel;
      logic mode;
      logic [3:0] fs;
      logic straps_done;
   } clkg_status_t;

endpackage

// File: design/clkg_strap_timer.sv
// Purpose: Strap window timer and strap latch.
// Assumes: Supply-good level is synchronous to the core clock.
// Notes:   Latched bits clear only with the power-on reset.
`timescale 1ns/1ps
`default_nettype none
module clkg_strap_timer #(
   parameter int unsigned CYCLES = clkg_pkg::STRAP_CYCLES_DEF,
   parameter int unsigned WIDTH = clkg_pkg::STRAPS
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic por_ok_i,
   input wire logic [WIDTH-1:0] pins_i,
   output logic done_o,
   output logic [WIDTH-1:0] straps_o
);

   // ==========================================================================
   // Checks
   // ==========================================================================
   if (CYCLES < 1) begin : g_bad_cycles
      $error("strap window must last one cycle at least");
   end

   localparam int unsigned CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

   // ==========================================================================
   // State
   // ==========================================================================
   typedef struct packed {
      logic [CNT_W-1:0] cnt; // Cycles since supply good
      logic done; // Window over, pins are outputs
      logic [WIDTH-1:0] straps; // Latched pin levels
   } clkg_tmr_t;

   clkg_tmr_t s_q;
   clkg_tmr_t s_d;

   // Count while supply is good, latch once at the end
   always_comb begin
      s_d = s_q;
      if (!s_q.done) begin
         if (!por_ok_i) begin
            s_d.cnt = '0; // Supply fell below threshold, start over
         end else if (s_q.cnt == LAST) begin
            s_d.done = 1'b1;
            s_d.straps = pins_i;
         end else begin
            s_d.cnt = s_q.cnt + 1'b1;
         end
      end
      // Once done nothing resamples the straps
   end

   // Power-on reset is the only clear
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign done_o = s_q.done;
   assign straps_o = s_q.straps;

endmodule
`default_nettype wire

// File: design/clkg_out_gate.sv
// Purpose: Registered gating cells for groups of clock outputs.
// Assumes: Sources are sampled levels on the core clock.
// Notes:   A stopped output is held low, never left floating.
`timescale 1ns/1ps
`default_nettype none
module clkg_out_gate #(
   parameter int unsigned WIDTH = 6
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [WIDTH-1:0] src_i,
   input wire logic [WIDTH-1:0] run_i,
   output logic [WIDTH-1:0] clk_o
);

   // ==========================================================================
   // Checks
   // ==========================================================================
   if (WIDTH < 1) begin : g_bad_width
      $error("gate group needs one output at least");
   end

   typedef struct packed {
      logic [WIDTH-1:0] out; // Gated levels
   } clkg_gate_t;

   clkg_gate_t s_q;
   clkg_gate_t s_d;

   // One cell per output
   for (genvar i = 0; i < WIDTH; i++) begin : g_cell
      always_comb begin
         s_d.out[i] = src_i[i] & run_i[i];
      end
   end

   // Outputs low from reset
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign clk_o = s_q.out;

endmodule
`default_nettype wire

// File: design/clkg_ctrl.sv
// Purpose: Strap, configuration and output control of the clock generator.
// Assumes: Synthesised clocks arrive as levels sampled on the core clock.
// Notes:   APB slave always ready; data and error settle in the setup cycle.
`timescale 1ns/1ps
`default_nettype none
module clkg_ctrl #(
   parameter int unsigned STRAP_CYCLES = clkg_pkg::STRAP_CYCLES_DEF,
   parameter int unsigned ADDR_W = 8,
   parameter int unsigned MEM_OUTS = 13,
   parameter int unsigned BUS_OUTS = 6
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // APB slave
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Supply and power management
   input wire logic por_ok_i,
   input wire logic power_down_n_i,
   // Clock sources
   input wire logic ref_clk_i,
   input wire logic mem_clk_in_i,
   input wire logic synth_cpu_clk_i,
   input wire logic synth_bus_clk_i,
   input wire logic synth_48_clk_i,
   input wire logic synth_24_clk_i,
   // CPU clocks
   output logic cpu_clk_true_o,
   output logic cpu_clk_comp_o,
   output logic cpu_clk_comp_oe_o,
   output logic chipset_cpu_clk_o,
   output logic chipset_cpu_clk_oe_o,
   // Memory fanout
   output logic [MEM_OUTS-1:0] mem_clk_fanout_o,
   // Bus clocks, the lowest two double as straps
   input wire logic [1:0] bus_clk_outs_i,
   output logic [BUS_OUTS-1:0] bus_clk_outs_o,
   output logic [BUS_OUTS-1:0] bus_clk_outs_oe_o,
   // USB reference, strap pin
   input wire logic usb_ref_clk_out_i,
   output logic usb_ref_clk_out_o,
   output logic usb_ref_clk_out_oe_o,
   // Super I/O clock, strap pin
   input wire logic superio_clk_out_i,
   output logic superio_clk_out_o,
   output logic superio_clk_out_oe_o,
   // Reference output one, strap pin
   input wire logic ref_clk_out1_i,
   output logic ref_clk_out1_o,
   output logic ref_clk_out1_oe_o,
   // Shared pin: reference output zero or stop input, active low
   input wire logic ref_clk_out0_i,
   output logic ref_clk_out0_o,
   output logic ref_clk_out0_oe_o,
   // Effective selection for the synthesiser
   output clkg_pkg::clkg_sel_t freq_sel_o,
   output logic straps_done_o
);

   // ==========================================================================
   // Checks
   // ==========================================================================
   if (ADDR_W < 8) begin : g_bad_addr
      $error("address must reach the status word");
   end
   if (MEM_OUTS != 13 || BUS_OUTS != 6) begin : g_bad_outs
      $error("enable grouping serves 13 memory and 6 bus outputs only");
   end

   // ==========================================================================
   // State
   // ==========================================================================
   typedef struct packed {
      logic [clkg_pkg::CFG_BYTES-1:0][7:0] cfg; // Configuration bytes
      logic [31:0] prdata; // Read data, loaded in setup
      logic pslverr; // Error, loaded in setup
      clkg_pkg::clkg_sel_t sel; // Effective selection
      logic cpu_t; // CPU true level
      logic cpu_c; // CPU complement level
      logic cpu_c_oe; // Complement driven
      logic cs_oe; // Open-drain pull-down active
      logic usb; // USB reference level
      logic sio; // Super I/O level
      logic ref_clk_out1; // Reference one level
      logic ref_clk_out0; // Reference zero level
   } clkg_ctrl_t;

   clkg_ctrl_t s_q;
   clkg_ctrl_t s_d;

   // ==========================================================================
   // Strap window
   // ==========================================================================
   logic [clkg_pkg::STRAPS-1:0] strap_pins; // Pin levels seen as inputs
   logic [clkg_pkg::STRAPS-1:0] straps; // Latched levels
   logic done; // Strap pins now outputs

   always_comb begin
      strap_pins = '0;
      strap_pins[clkg_pkg::STRAP_FS0] = ref_clk_out1_i;
      strap_pins[clkg_pkg::STRAP_FS1] = bus_clk_outs_i[1];
      strap_pins[clkg_pkg::STRAP_FS2] = usb_ref_clk_out_i;
      strap_pins[clkg_pkg::STRAP_FS3] = superio_clk_out_i;
      strap_pins[clkg_pkg::STRAP_MODE] = bus_clk_outs_i[0];
   end

   // Timer and latch
   clkg_strap_timer #(
      .CYCLES(STRAP_CYCLES),
      .WIDTH(clkg_pkg::STRAPS)
   ) u_strap (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .por_ok_i(por_ok_i),
      .pins_i(strap_pins),
      .done_o(done),
      .straps_o(straps)
   );

   // ==========================================================================
   // Conditions
   // ==========================================================================
   logic [3:0] fs; // Frequency straps
   logic stop_pin; // Shared pin acts as stop input
   logic cpu_stop; // Stop asserted
   logic pd; // Power-down asserted
   logic [7:0] b0; // Byte 0 shorthand
   logic [7:0] b2; // Byte 2 shorthand
   logic [7:0] b3; // Byte 3 shorthand
   logic [7:0] b5; // Byte 5 shorthand

   always_comb begin
      fs = straps[clkg_pkg::STRAP_FS3:clkg_pkg::STRAP_FS0];
      // Until the latch the mode is unknown, so the pin stays an input only
      stop_pin = done && (straps[clkg_pkg::STRAP_MODE] == clkg_pkg::MODE_CPU_STOP);
      cpu_stop = stop_pin && !ref_clk_out0_i;
      pd = !power_down_n_i;
      b0 = s_q.cfg[0];
      b2 = s_q.cfg[2];
      b3 = s_q.cfg[3];
      b5 = s_q.cfg[5];
   end

   // ==========================================================================
   // Gated groups
   // ==========================================================================
   logic [MEM_OUTS-1:0] mem_src; // Memory copies
   logic [MEM_OUTS-1:0] mem_run; // Memory enables
   logic [BUS_OUTS-1:0] bus_src; // Bus copies
   logic [BUS_OUTS-1:0] bus_run; // Bus enables

   // Three enable groups of four; the last output has no disable bit
   always_comb begin
      mem_src = {MEM_OUTS{mem_clk_in_i}};
      mem_run = '0;
      for (int g = 0; g < 3; g++) begin
         mem_run[g*4 +: 4] = {4{b3[clkg_pkg::B3_MEM_EN_BIT + g]}};
      end
      mem_run[MEM_OUTS-1] = 1'b1;
      if (pd) begin
         mem_run = '0;
      end
   end

   // Bus clocks share one synthesised rate, picked by the selection
   always_comb begin
      bus_src = {BUS_OUTS{synth_bus_clk_i}};
      bus_run = '0;
      bus_run[0] = b2[clkg_pkg::B2_PCI0_BIT];
      bus_run[BUS_OUTS-1:1] = b2[clkg_pkg::B2_PCI1_BIT +: BUS_OUTS-1];
      if (pd) begin
         bus_run = '0;
      end
   end

   clkg_out_gate #(
      .WIDTH(MEM_OUTS)
   ) u_mem_gate (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .src_i(mem_src),
      .run_i(mem_run),
      .clk_o(mem_clk_fanout_o)
   );

   clkg_out_gate #(
      .WIDTH(BUS_OUTS)
   ) u_bus_gate (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .src_i(bus_src),
      .run_i(bus_run),
      .clk_o(bus_clk_outs_o)
   );

   // ==========================================================================
   // APB decode
   // ==========================================================================
   logic setup; // Setup cycle of a transfer
   logic access; // Access cycle, completes at once
   logic aligned; // Word aligned address
   logic hit_cfg; // Configuration byte addressed
   logic hit_status; // Status word addressed
   logic [2:0] idx; // Configuration byte index
   clkg_pkg::clkg_status_t status; // Live status word

   always_comb begin
      setup = psel_i && !penable_i;
      access = psel_i && penable_i;
      aligned = (paddr_i[1:0] == 2'h0);
      hit_cfg = aligned && (paddr_i[7:0] >= clkg_pkg::CFG_BASE_OFS) && (paddr_i[7:0] < clkg_pkg::STATUS_OFS)
                && ((paddr_i >> 8) == '0);
      hit_status = (paddr_i[7:0] == clkg_pkg::STATUS_OFS) && ((paddr_i >> 8) == '0);
      idx = paddr_i[4:2];
      status = '0;
      status.straps_done = done;
      status.fs = fs;
      status.mode = straps[clkg_pkg::STRAP_MODE];
      status.sel = s_q.sel;
      status.power_down_n = power_down_n_i;
      status.cpu_stopped = cpu_stop;
   end

   // ==========================================================================
   // Next state
   // ==========================================================================
   logic run_cpu; // CPU clocks running
   logic run_ref_clk_out0; // Shared pin used as output
   logic [4:0] sw_code; // Software selection code

   always_comb begin
      s_d = s_q;
      run_cpu = !pd && !cpu_stop;
      run_ref_clk_out0 = !stop_pin;
      sw_code = {b0[clkg_pkg::B0_SEL4_BIT], b0[clkg_pkg::B0_SEL3_BIT], b0[clkg_pkg::B0_SEL0_BIT +: 3]};

      // Bus answers: data and error settle in setup, hold through access
      if (setup) begin
         s_d.pslverr = !(hit_cfg || hit_status);
         s_d.prdata = '0;
         if (hit_cfg) begin
            s_d.prdata = {24'h0, s_q.cfg[idx]};
         end else if (hit_status) begin
            s_d.prdata = status;
         end
      end
      // Writes take effect at the access edge; status is read-only
      if (access && pwrite_i && hit_cfg && pstrb_i[0]) begin
         s_d.cfg[idx] = pwdata_i[7:0];
      end

      // Frequency selection
      if (b0[clkg_pkg::B0_HWSW_BIT]) begin
         s_d.sel.sw = 1'b1;
         s_d.sel.code = sw_code;
         s_d.sel.spread = b0[clkg_pkg::B0_SEL3_BIT];
      end else begin
         s_d.sel.sw = 1'b0;
         s_d.sel.code = {1'b0, fs};
         s_d.sel.spread = fs[3] & fs[2];
      end

      // CPU pair and open-drain chipset copy
      if (run_cpu) begin
         s_d.cpu_t = synth_cpu_clk_i;
         s_d.cpu_c = !synth_cpu_clk_i;
         s_d.cpu_c_oe = 1'b1;
         s_d.cs_oe = !synth_cpu_clk_i;
      end else begin
         // Power-down and stop both float the complement
         s_d.cpu_t = 1'b0;
         s_d.cpu_c = 1'b0;
         s_d.cpu_c_oe = 1'b0;
         s_d.cs_oe = 1'b1;
      end

      // Strap-pin clocks; power-down wins over enables
      s_d.usb = !pd && b3[clkg_pkg::B3_USB_EN_BIT] && synth_48_clk_i;
      s_d.sio = !pd && b3[clkg_pkg::B3_SIO_EN_BIT]
                && (b3[clkg_pkg::B3_SEL48_BIT] ? synth_48_clk_i : synth_24_clk_i);
      s_d.ref_clk_out1 = !pd && b5[clkg_pkg::B5_REF_CLK_OUT1_BIT] && ref_clk_i;
      s_d.ref_clk_out0 = !pd && run_ref_clk_out0 && b5[clkg_pkg::B5_REF_CLK_OUT0_BIT] && ref_clk_i;
   end

   // ==========================================================================
   // Registers
   // ==========================================================================
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         s_q <= '0;
         for (int i = 0; i < clkg_pkg::CFG_BYTES; i++) begin
            s_q.cfg[i] <= clkg_pkg::CFG_RST[i];
         end
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   assign pready_o = 1'b1; // No wait states
   assign prdata_o = s_q.prdata;
   assign pslverr_o = s_q.pslverr;

   assign cpu_clk_true_o = s_q.cpu_t;
   assign cpu_clk_comp_o = s_q.cpu_c;
   assign cpu_clk_comp_oe_o = s_q.cpu_c_oe;
   assign chipset_cpu_clk_o = 1'b0; // Open drain only pulls low
   assign chipset_cpu_clk_oe_o = s_q.cs_oe;

   // Strap pins float until the latch; the first CPU cycle may be short
   // as outputs start mid-period
   assign bus_clk_outs_oe_o = {{(BUS_OUTS-2){1'b1}}, done, done};
   assign usb_ref_clk_out_o = s_q.usb;
   assign usb_ref_clk_out_oe_o = done;
   assign superio_clk_out_o = s_q.sio;
   assign superio_clk_out_oe_o = done;
   assign ref_clk_out1_o = s_q.ref_clk_out1;
   assign ref_clk_out1_oe_o = done;

   // Shared pin drives only once known to be an output
   assign ref_clk_out0_o = s_q.ref_clk_out0;
   assign ref_clk_out0_oe_o = done && !stop_pin;

   assign freq_sel_o = s_q.sel;
   assign straps_done_o = done;

endmodule
`default_nettype wire

// File: design/clkg_placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: bench/clkg_ctrl_checker.sv
// Purpose: Port assertions for the clock generator control
// Assumes: One core clock, synchronous active-low reset
// Notes: Bound to clkg_ctrl below the module
`timescale 1ns/1ps
`default_nettype none
module clkg_ctrl_checker #(
   parameter int unsigned STRAP_CYCLES = 20
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic por_ok_i,
   input wire logic power_down_n_i,
   input wire logic ref_clk_out0_i,
   input wire logic cpu_clk_true_o,
   input wire logic cpu_clk_comp_oe_o,
   input wire logic chipset_cpu_clk_oe_o,
   input wire logic usb_ref_clk_out_oe_o,
   input wire logic ref_clk_out0_oe_o,
   input wire clkg_pkg::clkg_sel_t freq_sel_o,
   input wire logic straps_done_o
);
   // ==========
   // Run of supply-good edges
   // ==========
   int unsigned run_q; // Saturates, so it never wraps
   int unsigned run_d;
   always_comb begin
      run_d = por_ok_i ? run_q + 1 : 0;
      if (run_d > STRAP_CYCLES) begin
         run_d = STRAP_CYCLES;
      end
   end
   always_ff @(posedge core_clk_i) begin
      run_q <= rstn_i ? run_d : 0;
   end
   // Stop input seen asserted on the shared pin
   wire logic stop_w = straps_done_o && !ref_clk_out0_oe_o && !ref_clk_out0_i;
   // ==========
   // Assertions
   // ==========
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   pd_force_a: assert property (!power_down_n_i |=> !cpu_clk_comp_oe_o && !cpu_clk_true_o)
      else $error("power-down left cpu clocks running");
   stop_force_a: assert property (stop_w |=> !cpu_clk_true_o && !cpu_clk_comp_oe_o)
      else $error("stop input did not halt cpu clocks");
   cs_phase_a: assert property ($past(rstn_i) |-> chipset_cpu_clk_oe_o == !cpu_clk_true_o)
      else $error("chipset clock out of phase");
   strap_float_a: assert property (!straps_done_o |-> !usb_ref_clk_out_oe_o && !ref_clk_out0_oe_o)
      else $error("strap pin driven inside window");
   done_keep_a: assert property (straps_done_o |=> straps_done_o)
      else $error("latched straps lost");
   window_len_a: assert property ($rose(straps_done_o) |-> run_q == STRAP_CYCLES)
      else $error("strap window ended early");
   window_end_a: assert property (run_q == STRAP_CYCLES |-> straps_done_o)
      else $error("strap window overran");
   hw_spread_a: assert property (!freq_sel_o.sw |-> freq_sel_o.spread == &freq_sel_o.code[3:2])
      else $error("spread enable wrong");
   cover property ($rose(straps_done_o));
   cover property (stop_w);
   cover property (freq_sel_o.sw);
endmodule
bind clkg_ctrl clkg_ctrl_checker #(.STRAP_CYCLES(STRAP_CYCLES)) chk_u (.*);
`default_nettype wire

// File: bench/clkg_board_model.sv
// Purpose: Board around the strap pins and the chipset stop driver
// Assumes: Strap resistors pull an undriven pin to its strap level
// Notes: Pins in strap order: ref_clk_out1, bus1, usb, superio, bus0
`timescale 1ns/1ps
`default_nettype none
module clkg_board_model (
   input wire logic [4:0] straps_i,
   input wire logic stop_n_i,
   input wire logic [4:0] out_i,
   input wire logic [4:0] oe_i,
   input wire logic ref_clk_out0_o_i,
   input wire logic ref_clk_out0_oe_i,
   output logic [4:0] pin_o,
   output logic ref_clk_out0_pin_o
);
   // Driver wins, else the resistor sets the level
   assign pin_o = (oe_i & out_i) | (~oe_i & straps_i);
   // Chipset drives stop only while the device floats the pin
   assign ref_clk_out0_pin_o = ref_clk_out0_oe_i ? ref_clk_out0_o_i : stop_n_i;
   // No check of the first CPU cycle: a short one is accepted
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Purpose: Self-checking bench for the clock generator control
// Assumes: Strap window shortened to 20 core cycles
// Notes: Clock outputs compared each cycle with a bench model
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic core_clk_i = 0, rstn_i, psel_i, penable_i, pwrite_i, por_ok_i, power_down_n_i;
   logic ref_clk_i, mem_clk_in_i, synth_cpu_clk_i, synth_bus_clk_i, synth_48_clk_i, synth_24_clk_i;
   logic usb_ref_clk_out_i, superio_clk_out_i, ref_clk_out1_i, ref_clk_out0_i, stop_n, err;
   logic pready_o, pslverr_o, cpu_clk_true_o, cpu_clk_comp_o, cpu_clk_comp_oe_o, chipset_cpu_clk_o;
   logic chipset_cpu_clk_oe_o, usb_ref_clk_out_o, usb_ref_clk_out_oe_o, superio_clk_out_o, straps_done_o;
   logic superio_clk_out_oe_o, ref_clk_out1_o, ref_clk_out1_oe_o, ref_clk_out0_o, ref_clk_out0_oe_o;
   logic mon, rnd, mode, s48, ben, pd_q, st_q, run;
   logic [1:0] bus_clk_outs_i;
   logic [3:0] pstrb_i = 4'h1, fs;
   logic [4:0] straps, pin;
   logic [5:0] bus_clk_outs_o, bus_clk_outs_oe_o, src, p;
   logic [6:0] sel;
   logic [7:0] paddr_i, wd;
   logic [12:0] mem_clk_fanout_o;
   logic [31:0] pwdata_i, prdata_o, rd, t, ex, obs;
   clkg_pkg::clkg_sel_t freq_sel_o;
   int error_cnt = 0, checks = 0, seed = 3540;
   clkg_ctrl #(.STRAP_CYCLES(20)) dut_u (.*);
   clkg_board_model brd_u (.straps_i(straps), .stop_n_i(stop_n), .ref_clk_out0_o_i(ref_clk_out0_o),
      .out_i({bus_clk_outs_o[0], superio_clk_out_o, usb_ref_clk_out_o, bus_clk_outs_o[1], ref_clk_out1_o}),
      .oe_i({bus_clk_outs_oe_o[0], superio_clk_out_oe_o, usb_ref_clk_out_oe_o,
      bus_clk_outs_oe_o[1], ref_clk_out1_oe_o}),
      .ref_clk_out0_oe_i(ref_clk_out0_oe_o), .pin_o(pin), .ref_clk_out0_pin_o(ref_clk_out0_i));
   assign {bus_clk_outs_i[0], superio_clk_out_i, usb_ref_clk_out_i, bus_clk_outs_i[1], ref_clk_out1_i} = pin;
   assign {ref_clk_i, mem_clk_in_i, synth_cpu_clk_i, synth_bus_clk_i, synth_48_clk_i, synth_24_clk_i} = src;
   always #5 core_clk_i = ~core_clk_i;
   // ==========
   // Shared tasks
   // ==========
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      do @(posedge core_clk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      {psel_i, penable_i} <= 2'b00;
   endtask
   task automatic close_out;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ==========
   // Random sources and per-cycle output model
   // ==========
   always @(posedge core_clk_i) begin
      t = $random(seed);
      run = mode | st_q;
      ex = pd_q ? {5'h0, run & !p[3], p[3] & run, run, !(p[3] & run), {13{p[4]}}, {6{p[2] & ben}}, p[1],
         s48 ? p[1] : p[0], p[5], p[5] & mode} : {9'h001, 23'h0};
      obs = {4'h0, chipset_cpu_clk_o, cpu_clk_comp_o & cpu_clk_comp_oe_o, cpu_clk_true_o, cpu_clk_comp_oe_o,
         chipset_cpu_clk_oe_o, mem_clk_fanout_o, bus_clk_outs_o, usb_ref_clk_out_o, superio_clk_out_o,
         ref_clk_out1_o, ref_clk_out0_o & mode};
      if (mon) begin
         chk("clocks", obs, ex);
      end
      src <= t[5:0];
      {p, pd_q, st_q} <= {src, power_down_n_i, ref_clk_out0_i};
      if (rnd) begin
         {power_down_n_i, stop_n, por_ok_i} <= {t[9:7] != 0, t[12:10] != 0, t[14:13] != 0};
      end
   end
   initial begin
      repeat (9000) @(posedge core_clk_i);
      error_cnt++;
      close_out;
   end
   // ==========
   // Main sequence, one pass per mode strap
   // ==========
   initial begin
      {rstn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, src, p} = '0;
      {por_ok_i, power_down_n_i, stop_n, mon, rnd, s48, ben, mode, straps} = 13'h0E0;
      for (int i = 0; i < 2; i++) begin
         {mon, rnd} <= 2'b00; // Random drive off a cycle before reset
         @(posedge core_clk_i);
         fs = $random(seed);
         mode = i[0];
         {rstn_i, por_ok_i, power_down_n_i, stop_n, mon, rnd, s48, ben, straps} <= {8'h31, mode, fs};
         repeat (12) @(posedge core_clk_i);
         rstn_i <= 1'b1;
         repeat (4) @(posedge core_clk_i);
         por_ok_i <= 1'b1;
         repeat (5) @(posedge core_clk_i);
         por_ok_i <= 1'b0;
         @(posedge core_clk_i);
         por_ok_i <= 1'b1;
         for (int n = 0; n < 200 && straps_done_o !== 1'b1; n++) @(posedge core_clk_i);
         repeat (2) @(posedge core_clk_i);
         sel = {2'b00, fs, fs[3] & fs[2]};
         chk("hardware selection", freq_sel_o, sel);
         chk("pin enables", {usb_ref_clk_out_oe_o, superio_clk_out_oe_o, ref_clk_out1_oe_o, ref_clk_out0_oe_o,
            bus_clk_outs_oe_o}, {3'h7, mode, 6'h3F});
         apb(1'b0, 8'h20, 0);
         chk("status", rd, {17'h0, 2'b01, sel, mode, fs, 1'b1});
         for (int b = 0; b < 8; b++) begin
            apb(1'b0, 8'(4 * b), 0);
            chk("config byte", rd, {24'h0, clkg_pkg::CFG_RST[b]});
         end
         apb(1'b0, 8'h24, 0);
         chk("unmapped read", {err, rd[30:0]}, 32'h80000000);
         wd = ($random(seed) & 8'h76) | 8'h08;
         apb(1'b1, 8'h00, {24'h0, wd});
         repeat (2) @(posedge core_clk_i);
         chk("software selection", freq_sel_o, {1'b1, wd[2], wd[1], wd[6:4], wd[1]});
         apb(1'b1, 8'h00, 32'h04);
         repeat (2) @(posedge core_clk_i);
         chk("selection restored", freq_sel_o, sel);
         if (i == 1) begin
            apb(1'b1, 8'h0C, 32'h77);
            apb(1'b1, 8'h08, 32'h00);
            {s48, ben} <= 2'b10;
         end
         repeat (3) @(posedge core_clk_i);
         {mon, rnd} <= 2'b11;
         repeat (400) @(posedge core_clk_i);
      end
      close_out;
   end
endmodule
`default_nettype wire
